// [verilog/tmc_pkg.sv]
// package: register map, field layout and mode encodings for the timer mode block
package tmc_pkg;
   localparam int          NUM_CH      = 8;
   localparam int          CNT_W       = 16;
   localparam int          ADDR_W      = 12;
   localparam int          IDX_W       = 3;
   // printed offsets are not multiples of four: keep them as indices
   localparam logic [19:0] CH0_MODE_IDX = 20'hf0190;
   localparam logic [19:0] CH7_MODE_IDX = 20'hf019e;
   // byte address of channel n mode word = 2 * (index - base index) + offsets below
   localparam logic [11:0] MODE_BASE    = 12'h000;
   localparam logic [11:0] INIT_BASE    = 12'h040;
   localparam logic [11:0] CTRL_OFS     = 12'h080;
   localparam logic [11:0] STAT_OFS     = 12'h084;
   localparam logic [11:0] CNT_BASE     = 12'h0c0;
   localparam logic [15:0] MODE_RESET   = 16'h0000;
   // writable bits: 15,14,12,11,10..8,7,6,3..0 (13,5,4 fixed zero)
   localparam logic [15:0] MODE_WMASK   = 16'hdfcf;
   localparam int          SPLIT_BIT    = 11;
   localparam logic [7:0]  BIT11_OK     = 8'h5e;   // channels 1,2,3,4,6
   localparam logic [7:0]  SPLIT_CH     = 8'h0a;   // channels 1,3
   localparam logic [7:0]  MASTER_CH    = 8'h54;   // channels 2,4,6

   typedef enum logic [1:0] {
      TMC_EDGE_FALL = 2'h0, TMC_EDGE_RISE = 2'h1,
      TMC_EDGE_LOW  = 2'h2, TMC_EDGE_HIGH = 2'h3
   } tmc_edge_t;

   typedef enum logic [2:0] {
      TMC_MD_INTERVAL = 3'h0, TMC_MD_CAPTURE = 3'h2, TMC_MD_EVENT = 3'h3,
      TMC_MD_ONECOUNT = 3'h4, TMC_MD_CAPONE  = 3'h6
   } tmc_mode_t;

   typedef enum logic [2:0] {
      TMC_TRG_SOFT = 3'h0, TMC_TRG_EDGE = 3'h1, TMC_TRG_BOTH = 3'h2
   } tmc_trg_t;

   typedef struct packed {
      logic [1:0] clk_sel;        // operating_clock_select
      logic       zero13;
      logic       count_clock_source;
      logic       bit11;          // split / master select
      logic [2:0] trigger_source_select;
      logic [1:0] input_edge_select;
      logic [1:0] zero54;
      logic [2:0] operation_mode_field;
      logic       start_behaviour_bit;
   } tmc_mode_reg_t;

   typedef struct packed {
      logic start_trig;
      logic capture_trig;
   } tmc_trig_t;
endpackage

// [verilog/tmc_edge_sel.sv]
// edge detector and trigger decode for one timer input pin
`timescale 1ns/1ps
module tmc_edge_sel (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 timer_input_pin,
   input  wire logic [1:0]           input_edge_select,
   input  wire logic [2:0]           trigger_source_select,
   output tmc_pkg::tmc_trig_t        trig
);
   logic pin_d_r;
   wire  rise_w = timer_input_pin & ~pin_d_r;
   wire  fall_w = ~timer_input_pin & pin_d_r;
   logic sel_w;
   logic start_w;
   logic cap_w;

   // previous pin level; input already synchronous
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pin_d_r <= 1'b0;
      else          pin_d_r <= timer_input_pin;
   end

   // valid edge by edge select
   always_comb begin
      unique case (input_edge_select)
         tmc_pkg::TMC_EDGE_FALL: sel_w = fall_w;
         tmc_pkg::TMC_EDGE_RISE: sel_w = rise_w;
         default:                sel_w = rise_w | fall_w;
      endcase
   end

   // start and capture triggers by source select
   always_comb begin
      start_w = 1'b0;
      cap_w   = 1'b0;
      if (trigger_source_select == tmc_pkg::TMC_TRG_EDGE) begin
         start_w = sel_w;
         cap_w   = sel_w;
      end else if (trigger_source_select == tmc_pkg::TMC_TRG_BOTH) begin
         if (input_edge_select == tmc_pkg::TMC_EDGE_HIGH) begin
            start_w = rise_w;
            cap_w   = fall_w;
         end else begin
            start_w = fall_w;
            cap_w   = rise_w;
         end
      end
   end

   assign trig = '{start_trig: start_w, capture_trig: cap_w};
endmodule

// [verilog/tmc_counter.sv]
// per-channel counter applying mode direction, start and retrigger handling
`timescale 1ns/1ps
module tmc_counter #(
   parameter int CNT_W = tmc_pkg::CNT_W
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             enable,
   input  wire logic             start,
   input  tmc_pkg::tmc_trig_t    trig,
   input  wire logic [2:0]       mode,
   input  wire logic             start_behaviour_bit,
   input  wire logic             split,
   input  wire logic [CNT_W-1:0] init_value,
   output logic [CNT_W-1:0]      count,
   output logic                  running,
   output logic                  channel_interrupt,
   output logic                  timer_output_pin
);
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic             run_r, irq_r, out_r;
   wire  up_w    = (mode == tmc_pkg::TMC_MD_CAPTURE) | (mode == tmc_pkg::TMC_MD_CAPONE);
   wire  one_w   = (mode == tmc_pkg::TMC_MD_ONECOUNT) | (mode == tmc_pkg::TMC_MD_CAPONE);
   wire  ext_st  = trig.start_trig & one_w;
   wire  st_w    = start | ext_st;
   // retrigger only in one-count with start bit 1; never in capture&one-count
   wire  retrg_w = run_r & st_w & (mode == tmc_pkg::TMC_MD_ONECOUNT)
                   & start_behaviour_bit;
   wire  first_w = ~run_r & st_w & enable;
   // start irq/output only for interval, capture, event modes
   wire  st_irq  = first_w & ~one_w & start_behaviour_bit;
   wire  lsb_w   = split ? (cnt_r[7:0] == 8'h00) : (cnt_r == '0);
   wire  tick_w  = (mode == tmc_pkg::TMC_MD_EVENT) ? trig.capture_trig : 1'b1;
   wire  zero_w  = run_r & ~up_w & tick_w & lsb_w;
   wire  cap_w   = run_r & up_w & trig.capture_trig;

   // next count: reload on start or accepted retrigger
   always_comb begin
      cnt_nxt = cnt_r;
      if (first_w | retrg_w)
         cnt_nxt = up_w ? '0 : init_value;
      else if (run_r & tick_w)
         cnt_nxt = up_w ? cnt_r + 1'b1 : (zero_w ? init_value : cnt_r - 1'b1);
   end

   // state; retrigger raises no interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         irq_r <= 1'b0;
         out_r <= 1'b0;
      end else begin
         cnt_r <= enable ? cnt_nxt : cnt_r;
         run_r <= enable & (run_r ? ~(one_w & (zero_w | cap_w)) : first_w);
         irq_r <= st_irq | zero_w | cap_w;
         out_r <= out_r ^ (st_irq | zero_w);
      end
   end

   assign count             = cnt_r;
   assign running           = run_r;
   assign channel_interrupt = irq_r;
   assign timer_output_pin  = out_r;

   a_retrig_noirq: assert property (@(posedge pclk) disable iff (!presetn)
      retrg_w |=> !irq_r || $past(zero_w)) else $error("retrigger raised irq");
   a_onecnt_start: assert property (@(posedge pclk) disable iff (!presetn)
      (first_w && one_w) |=> !irq_r) else $error("one-count start irq");
   a_start_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (first_w && !one_w && start_behaviour_bit) |=> irq_r) else $error("no start irq");
   a_start_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (first_w && !start_behaviour_bit && !zero_w) |=> $stable(out_r))
      else $error("output moved at start");
   a_retrig_reload: assert property (@(posedge pclk) disable iff (!presetn)
      (retrg_w && enable) |=> cnt_r == $past(init_value)) else $error("no reload");
   a_no_retrig: assert property (@(posedge pclk) disable iff (!presetn)
      (run_r && st_w && !start_behaviour_bit && mode == tmc_pkg::TMC_MD_ONECOUNT
       && !zero_w && enable) |=> cnt_r == $past(cnt_r) - 1'b1)
      else $error("retrigger not ignored");
   a_up_count: assert property (@(posedge pclk) disable iff (!presetn)
      (run_r && up_w && enable && !st_w && $stable(mode)) |=> cnt_r == $past(cnt_r) + 1'b1)
      else $error("capture not counting up");
   c_retrig:  cover property (@(posedge pclk) disable iff (!presetn) retrg_w);
   c_st_irq:  cover property (@(posedge pclk) disable iff (!presetn) st_irq);
   c_capture: cover property (@(posedge pclk) disable iff (!presetn) cap_w);
endmodule

// [verilog/tmc_top.sv]
// eight-channel timer mode control with apb register access
//
// Summary of operation
// - edge select 00 picks falling edge, 01 rising edge as valid edge
// - edge select 10: falling edge starts, rising edge captures (low width)
// - edge select 11: rising edge starts, falling edge captures (high width)
// - channels 0, 5, 7: bit 11 reads zero, writes ignored
// - mode 000 is interval timer, counting down
// - mode 010 is capture, counting up
// - mode 011 is event counter, counting down on external events
// - mode 100 is one-count, counting down
// - mode 110 is capture and one-count, counting up, for width measurement
// - interval/capture/event with start bit 0: no start irq, output unchanged
// - interval/capture/event with start bit 1: start raises irq, toggles output
// - one-count with start bit 0: start trigger ignored while counting
// - one-count with start bit 1: start trigger accepted while counting, no irq
// - accepted retrigger reloads counter and recounts without irq
// - capture and one-count: start bit 0, quiet start, retrigger ignored
// - in one-count the start bit governs retrigger only
// - source 000 software only, 001 selected edge, 010 both edges
// - channels 1, 3: bit 11 set gives 8-bit operation
// - channels 2, 4, 6: bit 11 set makes channel a master
`timescale 1ns/1ps
module tmc_top #(
   parameter int NUM_CH = tmc_pkg::NUM_CH,
   parameter int CNT_W  = tmc_pkg::CNT_W
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [tmc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [NUM_CH-1:0]         timer_input_pin,
   output logic      [NUM_CH-1:0]         timer_output_pin,
   output logic      [NUM_CH-1:0]         channel_interrupt,
   output logic      [NUM_CH-1:0]         master_channel_select
);
   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   logic [15:0]      mode_r   [NUM_CH];
   logic [CNT_W-1:0] init_r   [NUM_CH];
   logic [CNT_W-1:0] cnt_w    [NUM_CH];
   logic [NUM_CH-1:0] en_r;
   logic [NUM_CH-1:0] start_w;
   logic [NUM_CH-1:0] run_w;
   logic [31:0]       rd_nxt;
   logic [31:0]       prdata_r;
   logic              err_nxt;

   wire  access_w = psel & penable;
   wire  wr_w     = access_w & pwrite;
   wire  [2:0] idx_w   = paddr[tmc_pkg::IDX_W+1:2];
   wire  [11:0] page_w = {paddr[11:5], 5'h00};
   wire  hit_mode = (page_w == tmc_pkg::MODE_BASE);
   wire  hit_init = (page_w == tmc_pkg::INIT_BASE);
   wire  hit_cnt  = (page_w == tmc_pkg::CNT_BASE);
   wire  hit_ctrl = (paddr == tmc_pkg::CTRL_OFS);
   wire  hit_stat = (paddr == tmc_pkg::STAT_OFS);
   wire  mapped_w = hit_mode | hit_init | hit_cnt | hit_ctrl | hit_stat;

   // zero-wait slave: answer in the access cycle
   assign pready  = 1'b1;
   assign pslverr = access_w & ~mapped_w;

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (hit_mode)      rd_nxt = {16'h0000, mode_r[idx_w]};
      else if (hit_init) rd_nxt = {16'h0000, init_r[idx_w]};
      else if (hit_cnt)  rd_nxt = {16'h0000, cnt_w[idx_w]};
      else if (hit_ctrl) rd_nxt = {24'h000000, en_r};
      else if (hit_stat) rd_nxt = {24'h000000, run_w};
   end

   // data output from flop, loaded in setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)            prdata_r <= 32'h0000_0000;
      else if (psel & ~penable) prdata_r <= rd_nxt;
   end
   assign prdata = prdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // start pulses: writing 1 to control bit starts the channel
   assign start_w = (wr_w & hit_ctrl) ? pwdata[NUM_CH-1:0] : '0;

   // enable mirror; write sets start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)              en_r <= '0;
      else if (wr_w & hit_stat)  en_r <= en_r & ~pwdata[NUM_CH-1:0];
      else                       en_r <= en_r | start_w;
   end

   ////////////////////////////////////////////////////////////////////////////
   // channels
   for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
      tmc_pkg::tmc_mode_reg_t mr_w;
      tmc_pkg::tmc_trig_t     tr_w;
      wire  mwr_w = wr_w & hit_mode & (idx_w == 3'(n));
      wire  iwr_w = wr_w & hit_init & (idx_w == 3'(n));
      // bit 11 exists only where the channel has split or master meaning
      wire  [15:0] wmask_w = tmc_pkg::MODE_WMASK &
            ~(tmc_pkg::BIT11_OK[n] ? 16'h0000 : 16'h0800);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)   mode_r[n] <= tmc_pkg::MODE_RESET;
         else if (mwr_w) mode_r[n] <= pwdata[15:0] & wmask_w;
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)   init_r[n] <= '0;
         else if (iwr_w) init_r[n] <= pwdata[CNT_W-1:0];
      end

      assign mr_w = mode_r[n];
      // channel-type meaning of bit 11
      assign master_channel_select[n] = tmc_pkg::MASTER_CH[n] & mr_w.bit11;

      tmc_edge_sel u_edge (
         .pclk                  (pclk),
         .presetn               (presetn),
         .timer_input_pin       (timer_input_pin[n]),
         .input_edge_select     (mr_w.input_edge_select),
         .trigger_source_select (mr_w.trigger_source_select),
         .trig                  (tr_w)
      );

      tmc_counter #(.CNT_W(CNT_W)) u_cnt (
         .pclk                (pclk),
         .presetn             (presetn),
         .enable              (en_r[n] | start_w[n]),
         .start               (start_w[n]),
         .trig                (tr_w),
         .mode                (mr_w.operation_mode_field),
         .start_behaviour_bit (mr_w.start_behaviour_bit),
         .split               (tmc_pkg::SPLIT_CH[n] & mr_w.bit11),
         .init_value          (init_r[n]),
         .count               (cnt_w[n]),
         .running             (run_w[n]),
         .channel_interrupt   (channel_interrupt[n]),
         .timer_output_pin    (timer_output_pin[n])
      );

      //////////////////////////////////////////////////////////////////////
      // per-channel checks on what the register file hands each channel
      a_bit11_zero: assert property (@(posedge pclk) disable iff (!presetn)
         !tmc_pkg::BIT11_OK[n] |-> mode_r[n][tmc_pkg::SPLIT_BIT] == 1'b0)
         else $error("bit 11 set on fixed channel");
      // bit 11 keeps what software wrote where it has a split or master meaning
      a_bit11_kept: assert property (@(posedge pclk) disable iff (!presetn)
         (mwr_w && tmc_pkg::BIT11_OK[n])
         |=> mode_r[n][tmc_pkg::SPLIT_BIT] == $past(pwdata[tmc_pkg::SPLIT_BIT]))
         else $error("bit 11 write lost");
      // software-only source must keep the pin out of the trigger path
      a_soft_only: assert property (@(posedge pclk) disable iff (!presetn)
         (mr_w.trigger_source_select == tmc_pkg::TMC_TRG_SOFT)
         |-> (!tr_w.start_trig && !tr_w.capture_trig))
         else $error("pin trigger with software-only source");
      // a software start is honoured whatever the source setting
      a_sw_start: assert property (@(posedge pclk) disable iff (!presetn)
         (start_w[n] && !run_w[n]) |=> run_w[n])
         else $error("software start not taken");
      // one-count start leaves the output pin alone
      a_onecnt_out: assert property (@(posedge pclk) disable iff (!presetn)
         (start_w[n] && !run_w[n]
          && mr_w.operation_mode_field == tmc_pkg::TMC_MD_ONECOUNT)
         |=> $stable(timer_output_pin[n]))
         else $error("one-count start moved output");
      // start edge while measuring: counting goes on, no reload
      a_capone_ign: assert property (@(posedge pclk) disable iff (!presetn)
         (run_w[n] && en_r[n] && !start_w[n] && tr_w.start_trig && !tr_w.capture_trig
          && mr_w.operation_mode_field == tmc_pkg::TMC_MD_CAPONE)
         |=> cnt_w[n] == $past(cnt_w[n]) + 1'b1)
         else $error("measurement took a retrigger");
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus-side checks
   a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_w && hit_mode) |=> mode_r[$past(idx_w)][3:0] == $past(pwdata[3:0]))
      else $error("mode write lost");
   // read data stands from the access cycle on
   a_mode_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && hit_mode) |=> prdata == {16'h0000, mode_r[$past(idx_w)]})
      else $error("mode read wrong");
   // start bits set enables, stop bits clear them, nothing else moves
   a_start_set: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_w && hit_ctrl) |=> en_r == ($past(en_r) | $past(pwdata[NUM_CH-1:0])))
      else $error("start write mishandled");
   a_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_w && hit_stat) |=> en_r == ($past(en_r) & ~$past(pwdata[NUM_CH-1:0])))
      else $error("stop write mishandled");
   c_mode_wr: cover property (@(posedge pclk) disable iff (!presetn) wr_w && hit_mode);
   c_start:   cover property (@(posedge pclk) disable iff (!presetn) |start_w);
endmodule

// [testbench/tmc_pin_model.sv]
// pin-side model: drives the timer input pins from the requested levels
`timescale 1ns/1ps
module tmc_pin_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [7:0] level_req,
   output logic      [7:0] timer_input_pin
);
   ////////////////////////////////////////////////////////////////////////
   // pins move just after an edge, so they never race the sampling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_input_pin <= 8'h00;
      end else begin
         timer_input_pin <= level_req;
      end
   end
endmodule

// [testbench/test_tmc_top.sv]
// self-checking bench for the timer mode block
`timescale 1ns/1ps
module test_tmc_top;
   logic                         pclk = 1'b0;
   logic                         presetn = 1'b0;
   logic                         psel = 1'b0;
   logic                         penable = 1'b0;
   logic                         pwrite = 1'b0;
   logic [tmc_pkg::ADDR_W-1:0]   paddr = '0;
   logic [31:0]                  pwdata = 32'h0;
   logic [31:0]                  prdata;
   logic                         pready;
   logic                         pslverr;
   logic [7:0]                   level_req = 8'h00;
   logic [7:0]                   pin;
   logic [7:0]                   tout;
   logic [7:0]                   irq;
   logic [7:0]                   mst;
   logic [31:0]                  rd;
   logic                         er;
   int                           hits;
   int                           n_mismatch = 0;
   int                           num_checks = 0;
   // defined mode codes; table rows: mode, source, edge, idle, lead irq, trail irq
   localparam logic [2:0]  MODES [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
   localparam logic [2:0]  START_MD [3] = '{3'h0, 3'h2, 3'h3};
   localparam logic [10:0] EDGE_TBL [6] = '{
      {3'h2, 3'h1, 2'h0, 3'b001}, {3'h2, 3'h1, 2'h1, 3'b010},
      {3'h6, 3'h2, 2'h2, 3'b101}, {3'h6, 3'h2, 2'h3, 3'b001},
      {3'h2, 3'h0, 2'h0, 3'b000}, {3'h2, 3'h1, 2'h2, 3'b011}};

   ////////////////////////////////////////////////////////////////////////
   always #5 pclk = ~pclk;

   tmc_top u_tmc_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_input_pin(pin), .timer_output_pin(tout), .channel_interrupt(irq),
      .master_channel_select(mst));

   tmc_pin_model u_tmc_pin_model (
      .pclk(pclk), .presetn(presetn), .level_req(level_req), .timer_input_pin(pin));

   ////////////////////////////////////////////////////////////////////////
   // verdict and compare helpers
   task automatic conclude();
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   // one apb transfer; holds the request until pready is seen at an edge
   task automatic apb(input logic w, input int a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= tmc_pkg::ADDR_W'(a);
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         n_mismatch++;
         $display("Error at %0t: apb answer missing", $time);
         conclude();
      end
   endtask

   // counts interrupt pulses, sampled at edges so one-cycle pulses are seen
   task automatic watch(input int ch, input int n);
      hits = 0;
      repeat (n) begin
         @(posedge pclk);
         if (irq[ch] === 1'b1)
            hits++;
      end
   endtask

   function automatic logic [31:0] mw(logic [2:0] m, logic sb, logic [2:0] t, logic [1:0] e);
      return {16'h0, 5'h0, t, e, 2'h0, m, sb};
   endfunction

   // bit 11 only exists on channels 1,2,3,4,6; 13,5,4 always read zero
   function automatic logic [31:0] exp_mode(int ch, logic [15:0] d);
      logic [15:0] e;
      e = d & tmc_pkg::MODE_WMASK;
      if (!tmc_pkg::BIT11_OK[ch])
         e[11] = 1'b0;
      return {16'h0, e};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] d;
      logic [31:0] c1;
      logic [10:0] e;
      logic        old;
      int          ch;
      void'($urandom(58));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(0, 4 * i, 0);
         cmp_word(rd, 32'h0);
      end
      // random mode words, restricted to the defined codes
      repeat (40) begin
         ch = $urandom_range(7);
         d = 16'($urandom);
         d[3:1] = MODES[$urandom_range(4)];
         d[10:8] = 3'($urandom_range(2));
         if (d[3:1] == 3'h6)
            d[0] = 1'b0;
         apb(1, 4 * ch, {16'h0, d});
         apb(0, 4 * ch, 0);
         cmp_word(rd, exp_mode(ch, d));
         cmp_flag(mst[ch], tmc_pkg::MASTER_CH[ch] & d[11]);
      end
      apb(1, 12'hffc, 32'hffff);
      cmp_flag(er, 1'b1);
      apb(0, 12'hffc, 0);
      cmp_word(rd, 32'h0);
      for (int i = 0; i < 8; i++)
         apb(1, 4 * i, 32'h0);
      // start behaviour and count direction in the free-running modes
      for (int j = 0; j < 3; j++) begin
         for (int sb = 0; sb < 2; sb++) begin
            apb(1, 12'h008, mw(START_MD[j], sb[0], 3'h0, 2'h0));
            apb(1, 12'h048, 32'd50);
            old = tout[2];
            apb(1, 12'h080, 32'h4);
            watch(2, 6);
            cmp_flag(hits != 0, sb[0]);
            cmp_flag(tout[2] != old, sb[0]);
            apb(0, 12'h0c8, 0);
            c1 = rd;
            apb(0, 12'h0c8, 0);
            cmp_flag(START_MD[j] == 0 ? rd < c1 : START_MD[j] == 2 ? rd > c1 : rd == c1, 1'b1);
            apb(1, 12'h084, 32'h4);
         end
      end
      // retrigger in one-count mode
      for (int sb = 0; sb < 2; sb++) begin
         apb(1, 12'h010, mw(3'h4, sb[0], 3'h0, 2'h0));
         apb(1, 12'h050, 32'd200);
         apb(1, 12'h080, 32'h10);
         repeat (30) @(posedge pclk);
         apb(1, 12'h080, 32'h10);
         watch(4, 6);
         cmp_flag(hits != 0, 1'b0);
         apb(0, 12'h0d0, 0);
         cmp_flag(rd > 180, sb[0]);
         cmp_flag(rd < 200, 1'b1);
         apb(1, 12'h084, 32'h10);
      end
      // pin edges as start and capture triggers
      for (int j = 0; j < 6; j++) begin
         e = EDGE_TBL[j];
         level_req[3] <= e[2];
         apb(1, 12'h00c, mw(e[10:8], 1'b0, e[7:5], e[4:3]));
         apb(1, 12'h04c, 32'd1000);
         apb(1, 12'h080, 32'h8);
         watch(3, 6);
         cmp_flag(hits != 0, 1'b0);
         level_req[3] <= ~e[2];
         watch(3, 10);
         cmp_flag(hits != 0, e[1]);
         level_req[3] <= e[2];
         watch(3, 10);
         cmp_flag(hits != 0, e[0]);
         apb(1, 12'h084, 32'h8);
      end
      conclude();
   end
endmodule
